// *** verilog/rhd_pkg.sv ***
package rhd_pkg;

    // ==========================================================
    // Bus and timing
    // ==========================================================
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Power-good unit of time, as printed: 2 ms
    localparam int unsigned PGD_UNIT_MS = 2;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned PGD_UNIT_CYCLES = (PGD_UNIT_MS * NS_PER_MS) / CLK_PERIOD_NS;

    // ==========================================================
    // Command codes; the read code is the register index
    // ==========================================================
    localparam logic [7:0] CMD_RD_DESC_A = 8'h12;
    localparam logic [7:0] CMD_WR_DESC_A = 8'h92;
    localparam logic [7:0] CMD_RD_DESC_B = 8'h13;
    localparam logic [7:0] CMD_WR_DESC_B = 8'h93;
    localparam logic [7:0] CMD_WRITE_FLAG = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_DESC_A = {CMD_RD_DESC_A[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DESC_B = {CMD_RD_DESC_B[5:0], 2'h0};

    // ==========================================================
    // Descriptor A layout
    // ==========================================================
    localparam int unsigned PGD_MSB = 31;
    localparam int unsigned PGD_LSB = 24;
    localparam int unsigned NO_OVERCURRENT_PROTECT_BIT = 12;
    localparam int unsigned OVERCURRENT_REPORT_MODE_BIT = 11;
    localparam int unsigned DT_BIT = 10;
    localparam int unsigned NPS_BIT = 9;
    localparam int unsigned PSM_BIT = 8;
    localparam int unsigned NDP_MSB = 1;
    localparam int unsigned NDP_LSB = 0;
    localparam logic [7:0] PGD_RST = 8'hff;
    localparam logic NO_OVERCURRENT_PROTECT_RST = 1'b0;
    localparam logic OVERCURRENT_REPORT_MODE_RST = 1'b1;
    localparam logic DT_VAL = 1'b0;
    localparam logic NPS_RST = 1'b0;
    localparam logic PSM_RST = 1'b1;
    localparam logic [1:0] NDP_VAL = 2'h2;
    localparam int unsigned MAX_PORTS = 2;

    // ==========================================================
    // Descriptor B layout
    // ==========================================================
    localparam int unsigned PORT_POWER_CONTROL_MASK_W = 3;
    localparam int unsigned PORT_POWER_CONTROL_MASK_MSB = 18;
    localparam int unsigned PORT_POWER_CONTROL_MASK_LSB = 16;
    localparam logic [PORT_POWER_CONTROL_MASK_W-1:0] PORT_POWER_CONTROL_MASK_RST = 3'h0;

    localparam logic [DATA_W-1:0] DESC_A_USED = 32'hff001f03;
    localparam logic [DATA_W-1:0] DESC_B_USED = 32'h00070000;

endpackage

// *** verilog/rhd_power_timer.sv ***
module rhd_power_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic unit_tick,
    input wire logic powered,
    input wire logic [7:0] delay,
    output logic power_good
);
    import rhd_pkg::*;

    typedef struct packed {
        logic [7:0] units;
        logic good;
    } rhd_tmr_s;

    rhd_tmr_s st_r;
    rhd_tmr_s st_nxt;

    // ==========================================================
    // Whole units of 2 ms since power came on
    // ==========================================================
    // First unit may be short by up to one tick period, as counting starts
    // at power-on rather than at the next tick; software should add a margin.
    always_comb begin
        st_nxt = st_r;
        if (!powered) begin
            st_nxt.units = 8'h00;
            st_nxt.good = 1'b0;
        end else if (!st_r.good) begin
            if (st_r.units >= delay) begin
                st_nxt.good = 1'b1;
            end else if (unit_tick) begin
                st_nxt.units = st_r.units + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign power_good = st_r.good;

endmodule

// *** verilog/rhd_regs.sv ***
// Operation
// [R1] Descriptor A bits 31..24 hold a read/write power-good delay in 2 ms units, reset all ones.
// [R2] Bit 12 is a read/write no-overcurrent-protection bit, reset 0, which when set silences overcurrent reports.
// [R3] Bit 11 is a read/write overcurrent mode bit, reset 1, giving collective (0) or per-port (1) reporting.
// [R4] At reset the overcurrent mode matches the power switching mode.
// [R5] After power-up software writes the overcurrent mode to 0 and then to 1 for per-port reporting.
// [R6] Bit 10, the compound type flag, is read-only zero.
// [R7] Bit 9 is a read/write no-power-switch bit, reset 0; when set all ports are always powered.
// [R8] Bit 8 is a read/write power switch mode bit, reset 1, giving ganged (0) or individual (1) switching.
// [R9] In individual mode a masked port obeys only its own power commands and an unmasked one only global ones.
// [R10] Bits 1..0 read the downstream port count, value 2, read-only.
// [R11] Descriptor A is read with code 12h and written with code 92h as one 32-bit word.
// [R12] Descriptor B is read with code 13h, written with 93h, and holds the 3-bit port power mask at 18..16.
// [R13] Software programs descriptor B at initialisation; its reset value is a build choice.
// [R14] Both descriptors are writable at any time, always as whole 32-bit words.
// [R15] Reserved bits read as zero and ignore writes.
module rhd_regs #(
    parameter int unsigned NUM_PORTS = rhd_pkg::MAX_PORTS,
    parameter int unsigned UNIT_CYCLES = rhd_pkg::PGD_UNIT_CYCLES,
    parameter logic [rhd_pkg::PORT_POWER_CONTROL_MASK_W-1:0] PORT_POWER_CONTROL_MASK_RESET = rhd_pkg::PORT_POWER_CONTROL_MASK_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rhd_pkg::ADDR_W-1:0] paddr,
    input wire logic [rhd_pkg::DATA_W-1:0] pwdata,
    output logic [rhd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_power_set,
    input wire logic global_power_clear,
    input wire logic [NUM_PORTS-1:0] port_power_set,
    input wire logic [NUM_PORTS-1:0] port_power_clear,
    input wire logic [NUM_PORTS-1:0] overcurrent_pin,
    output logic [NUM_PORTS-1:0] port_power_on,
    output logic [NUM_PORTS-1:0] port_power_good,
    output logic overcurrent_global,
    output logic [NUM_PORTS-1:0] overcurrent_port
);
    import rhd_pkg::*;

    localparam int unsigned TICK_W = $clog2(UNIT_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UNIT_CYCLES - 1);

    typedef struct packed {
        logic [7:0] power_good_delay;
        logic no_overcurrent_protect;
        logic overcurrent_report_mode;
        logic no_power_switch;
        logic power_switch_mode;
        logic [PORT_POWER_CONTROL_MASK_W-1:0] port_power_control_mask;
        logic [NUM_PORTS-1:0] port_pwr;
        logic [NUM_PORTS-1:0] oc_meta;
        logic [NUM_PORTS-1:0] oc_sync;
        logic [NUM_PORTS-1:0] oc_port;
        logic oc_global;
        logic [TICK_W-1:0] tick_cnt;
        logic unit_tick;
        logic [DATA_W-1:0] rdata;
    } rhd_state_s;

    rhd_state_s st_r;
    rhd_state_s st_nxt;

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    function automatic logic [DATA_W-1:0] desc_a_word(input rhd_state_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[PGD_MSB:PGD_LSB] = s.power_good_delay;
        w[NO_OVERCURRENT_PROTECT_BIT] = s.no_overcurrent_protect;
        w[OVERCURRENT_REPORT_MODE_BIT] = s.overcurrent_report_mode;
        w[DT_BIT] = DT_VAL;
        w[NPS_BIT] = s.no_power_switch;
        w[PSM_BIT] = s.power_switch_mode;
        w[NDP_MSB:NDP_LSB] = NDP_VAL;
        desc_a_word = w;
    endfunction

    function automatic logic [DATA_W-1:0] desc_b_word(input rhd_state_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[PORT_POWER_CONTROL_MASK_MSB:PORT_POWER_CONTROL_MASK_LSB] = s.port_power_control_mask;
        desc_b_word = w;
    endfunction

    logic sel_a;
    logic sel_b;
    logic mapped;
    logic setup_ph;
    logic access_ph;
    logic wr_a;
    logic wr_b;

    assign sel_a = hit(paddr, ADDR_DESC_A);
    assign sel_b = hit(paddr, ADDR_DESC_B);
    assign mapped = sel_a | sel_b;
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_a = access_ph & pwrite & sel_a;
    assign wr_b = access_ph & pwrite & sel_b;

    // ==========================================================
    // Per-port power command routing
    // ==========================================================
    logic [NUM_PORTS-1:0] pwr_set;
    logic [NUM_PORTS-1:0] pwr_clr;

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_route
            always_comb begin
                if (!st_r.power_switch_mode) begin
                    // Ganged: any command moves every port
                    pwr_set[p] = global_power_set | (|port_power_set); // R8
                    pwr_clr[p] = global_power_clear | (|port_power_clear); // R8
                end else if (st_r.port_power_control_mask[p+1]) begin
                    pwr_set[p] = port_power_set[p]; // R9
                    pwr_clr[p] = port_power_clear[p]; // R9
                end else begin
                    pwr_set[p] = global_power_set; // R9
                    pwr_clr[p] = global_power_clear; // R9
                end
            end
        end
    endgenerate

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_nxt = st_r;

        // Zero wait states, so every access is taken whatever the host state
        if (wr_a) begin // R11 R14
            st_nxt.power_good_delay = pwdata[PGD_MSB:PGD_LSB]; // R1
            st_nxt.no_overcurrent_protect = pwdata[NO_OVERCURRENT_PROTECT_BIT]; // R2
            st_nxt.overcurrent_report_mode = pwdata[OVERCURRENT_REPORT_MODE_BIT]; // R3
            st_nxt.no_power_switch = pwdata[NPS_BIT]; // R7
            st_nxt.power_switch_mode = pwdata[PSM_BIT]; // R8
        end
        if (wr_b) begin // R12 R14
            st_nxt.port_power_control_mask = pwdata[PORT_POWER_CONTROL_MASK_MSB:PORT_POWER_CONTROL_MASK_LSB]; // R12
        end

        // Read data captured in setup so prdata comes from a flip-flop
        if (setup_ph && !pwrite) begin
            if (sel_a) begin
                st_nxt.rdata = desc_a_word(st_r); // R6 R10 R11 R15
            end else if (sel_b) begin
                st_nxt.rdata = desc_b_word(st_r); // R12 R15
            end else begin
                st_nxt.rdata = '0;
            end
        end

        // Port power; set wins over a clear in the same cycle
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (st_r.no_power_switch) begin
                st_nxt.port_pwr[p] = 1'b1; // R7
            end else if (pwr_set[p]) begin
                st_nxt.port_pwr[p] = 1'b1;
            end else if (pwr_clr[p]) begin
                st_nxt.port_pwr[p] = 1'b0;
            end
        end

        // Overcurrent pins are asynchronous
        st_nxt.oc_meta = overcurrent_pin;
        st_nxt.oc_sync = st_r.oc_meta;
        if (st_r.no_overcurrent_protect) begin
            st_nxt.oc_port = '0; // R2
            st_nxt.oc_global = 1'b0; // R2
        end else if (st_r.overcurrent_report_mode) begin
            st_nxt.oc_port = st_r.oc_sync; // R3
            st_nxt.oc_global = 1'b0;
        end else begin
            st_nxt.oc_port = '0;
            st_nxt.oc_global = |st_r.oc_sync; // R3
        end

        // 2 ms enable for the power-good timers
        if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = '0;
            st_nxt.unit_tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + TICK_W'(1);
            st_nxt.unit_tick = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.power_good_delay <= PGD_RST; // R1
            st_r.no_overcurrent_protect <= NO_OVERCURRENT_PROTECT_RST; // R2
            st_r.overcurrent_report_mode <= OVERCURRENT_REPORT_MODE_RST; // R3 R4
            st_r.no_power_switch <= NPS_RST; // R7
            st_r.power_switch_mode <= PSM_RST; // R8 R4
            st_r.port_power_control_mask <= PORT_POWER_CONTROL_MASK_RESET;
            st_r.port_pwr <= '0;
            st_r.oc_meta <= '0;
            st_r.oc_sync <= '0;
            st_r.oc_port <= '0;
            st_r.oc_global <= 1'b0;
            st_r.tick_cnt <= '0;
            st_r.unit_tick <= 1'b0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Power-good timers
    // ==========================================================
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_timer
            rhd_power_timer u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .unit_tick(st_r.unit_tick),
                .powered(st_r.port_pwr[p]),
                .delay(st_r.power_good_delay), // R1
                .power_good(port_power_good[p])
            );
        end
    endgenerate

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = st_r.rdata;
    assign pready = 1'b1; // R14
    assign pslverr = access_ph & ~mapped;
    assign port_power_on = st_r.port_pwr;
    assign overcurrent_port = st_r.oc_port;
    assign overcurrent_global = st_r.oc_global;

    // ==========================================================
    // Checks
    // ==========================================================
    logic written_a_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_a_r <= 1'b0;
        end else if (wr_a) begin
            written_a_r <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup_rd(logic sel);
        psel && !penable && !pwrite && sel;
    endsequence

    sequence s_access_rd;
        psel && penable && !pwrite && pready;
    endsequence

    sequence s_access_wr(logic sel);
        psel && penable && pwrite && pready && sel;
    endsequence

    AST_PGD_WRITE: assert property (s_access_wr(sel_a) // R1
            |=> st_r.power_good_delay == $past(pwdata[PGD_MSB:PGD_LSB]))
        else $error("power good delay not written");

    AST_NO_OVERCURRENT_PROTECT_SILENT: assert property (st_r.no_overcurrent_protect // R2
            |=> !overcurrent_global && overcurrent_port == '0)
        else $error("overcurrent reported with protection off");

    AST_OC_PER_PORT: assert property (!st_r.no_overcurrent_protect && st_r.overcurrent_report_mode // R3
            |=> overcurrent_port == $past(st_r.oc_sync) && !overcurrent_global)
        else $error("per-port overcurrent report wrong");

    AST_OC_COLLECT: assert property (!st_r.no_overcurrent_protect && !st_r.overcurrent_report_mode // R3
            |=> overcurrent_global == ($past(st_r.oc_sync) != '0) && overcurrent_port == '0)
        else $error("collective overcurrent report wrong");

    AST_MODES_MATCH: assert property (!written_a_r |-> st_r.overcurrent_report_mode == st_r.power_switch_mode) // R4
        else $error("reset modes differ");

    AST_DT_NDP_READ: assert property (s_setup_rd(sel_a) ##1 s_access_rd // R6
            |-> prdata[DT_BIT] == DT_VAL && prdata[NDP_MSB:NDP_LSB] == NDP_VAL)
        else $error("read-only fields of descriptor a wrong");

    AST_NPS_ON: assert property (st_r.no_power_switch |=> port_power_on == '1) // R7
        else $error("ports not always powered");

    AST_GANGED_SET: assert property (!st_r.no_power_switch && !st_r.power_switch_mode && global_power_set // R8
            |=> port_power_on == '1)
        else $error("ganged set did not power all ports");

    AST_MASK_IGNORES_GLOBAL: assert property (!st_r.no_power_switch && st_r.power_switch_mode // R9
            && st_r.port_power_control_mask[1] && !port_power_set[0] && !port_power_clear[0]
            |=> port_power_on[0] == $past(port_power_on[0]))
        else $error("masked port followed a global command");

    AST_UNMASKED_GLOBAL_CLR: assert property (!st_r.no_power_switch && st_r.power_switch_mode // R9
            && !st_r.port_power_control_mask[1] && global_power_clear && !global_power_set
            |=> !port_power_on[0])
        else $error("unmasked port ignored global clear");

    AST_READ_A: assert property (s_setup_rd(sel_a) ##1 s_access_rd // R11
            |-> prdata == desc_a_word(st_r) && (prdata & ~DESC_A_USED) == '0)
        else $error("descriptor a read data wrong");

    AST_PORT_POWER_CONTROL_MASK_WRITE: assert property (s_access_wr(sel_b) // R12
            |=> st_r.port_power_control_mask == $past(pwdata[PORT_POWER_CONTROL_MASK_MSB:PORT_POWER_CONTROL_MASK_LSB]))
        else $error("port power mask not written");

    AST_ACCESS_READY: assert property (psel && penable |-> pready) // R14
        else $error("access stalled");

    AST_READ_B_RESERVED: assert property (s_setup_rd(sel_b) ##1 s_access_rd // R15
            |-> (prdata & ~DESC_B_USED) == '0)
        else $error("reserved bits of descriptor b not zero");

    // Unmapped accesses must not disturb either descriptor
    sequence s_access_unmapped;
        psel && penable && !sel_a && !sel_b;
    endsequence

    AST_UNMAPPED_ERROR: assert property (s_access_unmapped |-> pslverr) // R15
        else $error("unmapped access not flagged");

    AST_UNMAPPED_IGNORED: assert property (s_access_unmapped ##0 pwrite // R15
            |=> $stable(st_r.power_good_delay) && $stable(st_r.port_power_control_mask))
        else $error("unmapped write changed a descriptor");

    AST_MASKED_PORT_SET: assert property (!st_r.no_power_switch && st_r.power_switch_mode // R9
            && st_r.port_power_control_mask[2] && port_power_set[1]
            |=> port_power_on[1])
        else $error("masked port ignored its own set");

    AST_UNMASKED_IGNORES_PORT: assert property (!st_r.no_power_switch && st_r.power_switch_mode // R9
            && !st_r.port_power_control_mask[1] && !global_power_set && !global_power_clear
            |=> port_power_on[0] == $past(port_power_on[0]))
        else $error("unmasked port followed a port command");

endmodule

// *** testbench/root_hub_descriptor_regs_test.sv ***
module root_hub_descriptor_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rhd_pkg::*;

    typedef struct {
        string name;
        logic [32:0] exp;
        logic [32:0] mask;
    } rhd_note_s;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic global_power_set;
    logic global_power_clear;
    logic [1:0] port_power_set;
    logic [1:0] port_power_clear;
    logic [1:0] overcurrent_pin;
    logic [1:0] port_power_on;
    logic [1:0] port_power_good;
    logic overcurrent_global;
    logic [1:0] overcurrent_port;
    logic probe;
    int err_count;
    int checked;
    rhd_note_s notes[$];
    rhd_note_s note;
    logic [32:0] seen;
    logic [31:0] w;
    logic [31:0] last_a;

    // Short power-good unit keeps the run brief
    rhd_regs #(.NUM_PORTS(2), .UNIT_CYCLES(10), .PORT_POWER_CONTROL_MASK_RESET(3'h0)) i_rhd_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_power_set(global_power_set), .global_power_clear(global_power_clear),
        .port_power_set(port_power_set), .port_power_clear(port_power_clear),
        .overcurrent_pin(overcurrent_pin), .port_power_on(port_power_on),
        .port_power_good(port_power_good), .overcurrent_global(overcurrent_global),
        .overcurrent_port(overcurrent_port)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ==========================================================
    // Reporting
    // ==========================================================
    task automatic check(input string name, input logic [32:0] s, input logic [32:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Oldest note is matched to each completed transfer or probe
    always @(posedge pclk) begin
        if ((psel && penable && pready) || probe) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("[FAIL] note queue expected filled seen empty");
            end else begin
                note = notes.pop_front();
                if (probe) begin
                    seen = {26'h0, overcurrent_global, overcurrent_port, port_power_good, port_power_on};
                end else begin
                    seen = {pslverr, pwrite ? 32'h0 : prdata};
                end
                check(note.name, seen & note.mask, note.exp & note.mask);
            end
        end
    end

    // ==========================================================
    // Drivers
    // ==========================================================
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                       input string name);
        int n;
        notes.push_back('{name, e, {33{1'b1}}});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic gs, input logic gc, input logic [1:0] ps, input logic [1:0] pc);
        @(posedge pclk);
        global_power_set <= gs;
        global_power_clear <= gc;
        port_power_set <= ps;
        port_power_clear <= pc;
        @(posedge pclk);
        global_power_set <= 1'b0;
        global_power_clear <= 1'b0;
        port_power_set <= 2'h0;
        port_power_clear <= 2'h0;
        repeat (3) @(posedge pclk);
    endtask

    // Bits: 6 global oc, 5..4 port oc, 3..2 good, 1..0 on
    task automatic probe_obs(input string name, input logic [6:0] e, input logic [6:0] m);
        notes.push_back('{name, {26'h0, e}, {26'h0, m}});
        @(posedge pclk);
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, probe, global_power_set, global_power_clear} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        {port_power_set, port_power_clear, overcurrent_pin} = 6'h0;
        err_count = 0;
        checked = 0;
        void'($urandom(16));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_DESC_A, 32'h0, {1'b0, 32'hff000902}, "desc_a reset");
        apb(1'b0, ADDR_DESC_B, 32'h0, {1'b0, 32'h0}, "desc_b reset");
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom();
            last_a = (w & 32'hff001b00) | 32'h2;
            apb(1'b1, ADDR_DESC_A, w, 33'h0, "desc_a write");
            apb(1'b0, ADDR_DESC_A, 32'h0, {1'b0, last_a}, "desc_a read");
            apb(1'b1, ADDR_DESC_B, ~w, 33'h0, "desc_b write");
            apb(1'b0, ADDR_DESC_B, 32'h0, {1'b0, ~w & 32'h00070000}, "desc_b read");
        end
        apb(1'b1, 8'h50, 32'hffffffff, {1'b1, 32'h0}, "unmapped write");
        apb(1'b0, 8'h50, 32'h0, {1'b1, 32'h0}, "unmapped read");
        apb(1'b0, ADDR_DESC_A, 32'h0, {1'b0, last_a}, "desc_a kept");
        $display("test register_access done");
        // Ganged switching, two power-good units
        apb(1'b1, ADDR_DESC_A, 32'h02000800, 33'h0, "ganged setup");
        // Earlier random writes may have left ports on; start from off
        cmd(1'b0, 1'b1, 2'h0, 2'h0);
        cmd(1'b1, 1'b0, 2'h0, 2'h0);
        probe_obs("ganged on", 7'h03, 7'h0f);
        repeat (40) @(posedge pclk);
        probe_obs("power good", 7'h0f, 7'h0f);
        cmd(1'b0, 1'b1, 2'h0, 2'h0);
        probe_obs("ganged off", 7'h00, 7'h0f);
        // Individual switching, port 1 masked
        apb(1'b1, ADDR_DESC_A, 32'h02000900, 33'h0, "individual setup");
        apb(1'b1, ADDR_DESC_B, 32'h00040000, 33'h0, "mask setup");
        cmd(1'b1, 1'b0, 2'h0, 2'h0);
        probe_obs("global set unmasked", 7'h01, 7'h03);
        cmd(1'b0, 1'b0, 2'h2, 2'h0);
        probe_obs("port set masked", 7'h03, 7'h03);
        cmd(1'b0, 1'b0, 2'h0, 2'h1);
        probe_obs("port clear unmasked", 7'h03, 7'h03);
        cmd(1'b0, 1'b1, 2'h0, 2'h0);
        probe_obs("global clear", 7'h02, 7'h03);
        cmd(1'b0, 1'b0, 2'h0, 2'h2);
        probe_obs("port clear masked", 7'h00, 7'h03);
        apb(1'b1, ADDR_DESC_A, 32'h02000b00, 33'h0, "always powered");
        repeat (3) @(posedge pclk);
        probe_obs("no switching on", 7'h03, 7'h03);
        $display("test power_switching done");
        // Software toggles the mode low then high after power-up
        overcurrent_pin <= 2'h2;
        apb(1'b1, ADDR_DESC_A, 32'h02000000, 33'h0, "collective mode");
        repeat (5) @(posedge pclk);
        probe_obs("collective oc", 7'h40, 7'h70);
        apb(1'b1, ADDR_DESC_A, 32'h02000800, 33'h0, "per-port mode");
        repeat (5) @(posedge pclk);
        probe_obs("per-port oc", 7'h20, 7'h70);
        apb(1'b1, ADDR_DESC_A, 32'h02001800, 33'h0, "no protection");
        repeat (5) @(posedge pclk);
        probe_obs("oc silenced", 7'h00, 7'h70);
        overcurrent_pin <= 2'h0;
        $display("test overcurrent done");
        repeat (3) @(posedge pclk);
        if (notes.size() != 0) begin
            err_count++;
            $display("[FAIL] note queue expected 0 seen %0d", notes.size());
        end
        tally_and_finish();
    end
endmodule
